// ===== verilog/trim_sequencer.sv
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module trim_sequencer #(
  parameter logic [31:0] POWERON_DELAY_SHORT = 32'h0010_0000,
  parameter logic [31:0] POWERON_DELAY_LONG  = 32'h0100_0000,
  parameter logic [31:0] RES_TRIM_CYCLES     = 32'h0000_4000,
  parameter logic [31:0] LIN_TRIM_CYCLES     = 32'h0001_0000
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    start_pin,
  input  wire logic                    poweron_trim_delay_select,
  input  wire logic                    serial_control_mode,
  input  wire logic                    output_clock_reset_input,
  input  wire trim_pkg::sample_s       sample_in,
  output trim_pkg::sample_s            sample_out,
  output logic                         output_clock,
  output logic                         trim_in_progress
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s1_q;
  logic [3:0] pins_s2_q;
  logic       dsel_prev_q;
  logic       start_s;
  logic       dsel_s;
  logic       scm_s;
  logic       trig_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_s1_q <= 4'h0;
      pins_s2_q <= 4'h0;
    end else begin
      pins_s1_q <= {output_clock_reset_input, serial_control_mode,
                    poweron_trim_delay_select, start_pin};
      pins_s2_q <= pins_s1_q;
    end
  end

  assign start_s = pins_s2_q[0];
  assign dsel_s  = pins_s2_q[1];
  assign scm_s   = pins_s2_q[2];
  assign trig_s  = pins_s2_q[3];

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  logic [15:0]             config_q;
  logic [15:0]             adjust_q;
  logic                    wr_pend_q;
  logic [7:0]              wr_addr_q;
  logic                    skipped_q;
  logic                    armed_q;
  trim_pkg::trim_state_e   state_q;
  logic                    addr_phase;
  logic [31:0]             status_val;

  assign addr_phase = hsel && hready && htrans[1];
  assign status_val = {28'h0000000, armed_q, skipped_q,
                       state_q == trim_pkg::ST_FLUSH, trim_in_progress};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && !hwrite) begin
        if (haddr[7:0] == trim_pkg::CONFIG_OFFSET) begin
          hrdata <= {16'h0000, config_q};
        end else if (haddr[7:0] == trim_pkg::ADJUST_OFFSET) begin
          hrdata <= {16'h0000, adjust_q};
        end else if (haddr[7:0] == trim_pkg::STATUS_OFFSET) begin
          hrdata <= status_val;
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_q <= trim_pkg::CONFIG_RESET;
      adjust_q <= trim_pkg::ADJUST_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == trim_pkg::CONFIG_OFFSET) begin
        config_q <= hwdata[15:0];
      end else if (wr_addr_q == trim_pkg::ADJUST_OFFSET) begin
        adjust_q <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Start request qualification
  // ----------------------------------------------------------------
  logic        start_req;
  logic [31:0] low_cnt_q;
  logic [31:0] high_cnt_q;
  logic        launch_cmd;
  logic        launch_dsel;
  logic        launch;

  // Pin ORed with bit in serial mode
  assign start_req = start_s ||
                     (scm_s && config_q[trim_pkg::START_BIT]);
  assign launch_cmd = armed_q && start_req &&
                      (high_cnt_q == trim_pkg::START_HIGH_MIN - 32'h1);
  assign launch_dsel = (dsel_s != dsel_prev_q);
  assign launch = (state_q == trim_pkg::ST_IDLE ||
                   state_q == trim_pkg::ST_FLUSH) &&
                  (launch_cmd || launch_dsel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_q  <= 32'h0;
      high_cnt_q <= 32'h0;
      armed_q    <= 1'b0;
    end else if (!start_req) begin
      high_cnt_q <= 32'h0;
      if (low_cnt_q == trim_pkg::START_LOW_MIN - 32'h1) begin
        armed_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + 32'h1;
      end
    end else begin
      low_cnt_q <= 32'h0;
      if (launch_cmd) begin
        armed_q <= 1'b0;
      end else if (armed_q) begin
        high_cnt_q <= high_cnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim sequencer
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] poweron_delay;

  assign poweron_delay = dsel_s ? POWERON_DELAY_LONG : POWERON_DELAY_SHORT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsel_prev_q <= 1'b0;
    end else begin
      dsel_prev_q <= dsel_s;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= trim_pkg::ST_INIT;
      cnt_q      <= 32'h0;
      skipped_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      case (state_q)
        trim_pkg::ST_INIT: begin
          if (cnt_q == trim_pkg::SYNC_SETTLE) begin
            cnt_q <= 32'h0;
            if (start_req) begin
              skipped_q <= 1'b1;
              state_q   <= trim_pkg::ST_IDLE;
            end else begin
              state_q   <= trim_pkg::ST_POWERON_WAIT;
            end
          end
        end
        trim_pkg::ST_POWERON_WAIT: begin
          if (cnt_q >= poweron_delay - 32'h1) begin
            cnt_q      <= 32'h0;
            state_q    <= adjust_q[trim_pkg::SEQ_SELECT_BIT] ?
                          trim_pkg::ST_RES_TRIM : trim_pkg::ST_LIN_TRIM;
          end
        end
        trim_pkg::ST_RES_TRIM: begin
          if (cnt_q == RES_TRIM_CYCLES - 32'h1) begin
            cnt_q   <= 32'h0;
            state_q <= trim_pkg::ST_LIN_TRIM;
          end
        end
        trim_pkg::ST_LIN_TRIM: begin
          if (cnt_q == LIN_TRIM_CYCLES - 32'h1) begin
            cnt_q   <= 32'h0;
            state_q <= trim_pkg::ST_FLUSH;
          end
        end
        default: begin
          if (state_q == trim_pkg::ST_FLUSH &&
              cnt_q == trim_pkg::FLUSH_CYCLES - 32'h1) begin
            state_q <= trim_pkg::ST_IDLE;
          end
          if (launch) begin
            cnt_q      <= 32'h0;
            state_q    <= adjust_q[trim_pkg::SEQ_SELECT_BIT] ?
                          trim_pkg::ST_RES_TRIM : trim_pkg::ST_LIN_TRIM;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  trim_pkg::sample_s stage1_q;
  trim_pkg::sample_s stage2_q;
  logic              blank;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_in_progress <= 1'b0;
      output_clock     <= 1'b0;
    end else begin
      trim_in_progress <= (state_q == trim_pkg::ST_RES_TRIM) ||
                          (state_q == trim_pkg::ST_LIN_TRIM);
      output_clock     <= !output_clock;
    end
  end

  assign blank = trim_in_progress || (state_q == trim_pkg::ST_FLUSH) ||
                 (state_q == trim_pkg::ST_RES_TRIM) ||
                 (state_q == trim_pkg::ST_LIN_TRIM);

  // Data delayed to match trigger sync
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= sample_in;
      stage2_q <= stage1_q;
    end
  end

  generate
    for (genvar b = 0; b < trim_pkg::BUS_N; b++) begin : g_bus
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sample_out.word[b] <= '0;
        end else if (blank) begin
          sample_out.word[b] <= '0;
        end else if (config_q[trim_pkg::TRIG_CAPTURE_BIT]) begin
          sample_out.word[b] <= {stage2_q.word[b][trim_pkg::WORD_W-1:1],
                                 trig_s};
        end else begin
          sample_out.word[b] <= stage2_q.word[b];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_out.over_range <= 2'h0;
    end else begin
      sample_out.over_range <= blank ? 2'h0 : stage2_q.over_range;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  trig_lsb_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!blank && config_q[trim_pkg::TRIG_CAPTURE_BIT])
      |=> sample_out.word[0][0] == $past(trig_s))
    else $error("trigger bit not in word lsb");

  trig_latency_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($past(hresetn, 2) && !blank &&
     !config_q[trim_pkg::TRIG_CAPTURE_BIT])
      |=> sample_out.word[1] == $past(sample_in.word[1], 3))
    else $error("data latency differs from trigger latency");

  launch_qual_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    launch_cmd |-> $past(start_req, 1) && armed_q)
    else $error("launch without qualified start");

  rearm_low_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    launch_cmd |=> !armed_q)
    else $error("start not disarmed after launch");

  running_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == trim_pkg::ST_LIN_TRIM) |=> trim_in_progress)
    else $error("indicator low during trim");

  skip_poweron_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == trim_pkg::ST_INIT && cnt_q == trim_pkg::SYNC_SETTLE
     && start_req) |=> state_q == trim_pkg::ST_IDLE && skipped_q)
    else $error("power-on trim not skipped");

  short_seq_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (launch && !adjust_q[trim_pkg::SEQ_SELECT_BIT])
      |=> state_q == trim_pkg::ST_LIN_TRIM)
    else $error("resistor trim not skipped");

  full_seq_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (launch && adjust_q[trim_pkg::SEQ_SELECT_BIT])
      |=> state_q == trim_pkg::ST_RES_TRIM)
    else $error("resistor trim not run");

  blank_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trim_in_progress |=> sample_out == '0)
    else $error("outputs not low during trim");

  flush_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(trim_in_progress) |-> state_q == trim_pkg::ST_FLUSH
      ##1 (sample_out == '0) [*8])
    else $error("outputs valid before flush ends");

  dsel_toggle_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == trim_pkg::ST_IDLE && dsel_s != dsel_prev_q)
      |=> state_q inside {trim_pkg::ST_RES_TRIM, trim_pkg::ST_LIN_TRIM})
    else $error("delay select toggle did not launch");

endmodule

// ===== verilog/trim_pkg.sv
package trim_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CONFIG_OFFSET      = 8'h00;
  localparam logic [7:0]  ADJUST_OFFSET      = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET      = 8'h08;
  localparam int          START_BIT          = 15;
  localparam int          TRIG_CAPTURE_BIT   = 3;
  localparam int          SEQ_SELECT_BIT     = 14;
  localparam int          ST_RUNNING_BIT     = 0;
  localparam int          ST_FLUSHING_BIT    = 1;
  localparam int          ST_SKIPPED_BIT     = 2;
  localparam int          ST_ARMED_BIT       = 3;
  localparam logic [15:0] CONFIG_RESET       = 16'h0000;
  localparam logic [15:0] ADJUST_RESET       = 16'h4000;

  // ----------------------------------------------------------------
  // Timing in sampling clock cycles
  // ----------------------------------------------------------------
  localparam logic [31:0] START_LOW_MIN      = 32'h0000_0050;
  localparam logic [31:0] START_HIGH_MIN     = 32'h0000_0050;
  localparam logic [31:0] FLUSH_CYCLES       = 32'h0000_003C;
  localparam logic [31:0] SYNC_SETTLE        = 32'h0000_0003;

  localparam int          WORD_W             = 12;
  localparam int          BUS_N              = 4;

  typedef struct packed {
    logic [BUS_N-1:0][WORD_W-1:0] word;
    logic [1:0]                   over_range;
  } sample_s;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_POWERON_WAIT,
    ST_IDLE,
    ST_RES_TRIM,
    ST_LIN_TRIM,
    ST_FLUSH
  } trim_state_e;

endpackage

// ===== testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic hclk,
  output logic      start_pin,
  output logic      poweron_trim_delay_select,
  output logic      serial_control_mode,
  output logic      output_clock_reset_input
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // levels held
  initial begin
    start_pin                 = 1'b0;
    poweron_trim_delay_select = 1'b0;
    serial_control_mode       = 1'b0;
    output_clock_reset_input  = 1'b0;
  end

  task set_pins(input logic s, input logic d, input logic m, input logic t);
    @(posedge hclk);
    start_pin                 <= s;
    poweron_trim_delay_select <= d;
    serial_control_mode       <= m;
    output_clock_reset_input  <= t;
  endtask

  // ----------------------------------------------------------------
  // Start request
  // ----------------------------------------------------------------
  // low, high, back low
  task req(input int lo, input int hi);
    @(posedge hclk);
    start_pin <= 1'b0;
    repeat (lo) @(posedge hclk);
    start_pin <= 1'b1;
    repeat (hi) @(posedge hclk);
    start_pin <= 1'b0;
  endtask
endmodule

// ===== testbench/trim_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module trim_sequencer_tb;
  localparam int RES = 10;
  localparam int LIN = 10;
  logic              hclk, hresetn, hsel, hwrite, rd_pend;
  logic [31:0]       haddr, hwdata, hrdata, rng, exp_v;
  logic [1:0]        htrans;
  logic              hreadyout, hresp, output_clock, trim_in_progress;
  logic              start_pin, dly_sel, ser_mode, trig;
  logic [63:0]       r;
  trim_pkg::sample_s sample_in, sample_out;
  logic [31:0]       exp_q[$];
  int                n_fail, samples_checked;

  trim_sequencer #(
    .POWERON_DELAY_SHORT(32'h14), .POWERON_DELAY_LONG(32'h28),
    .RES_TRIM_CYCLES(32'hA), .LIN_TRIM_CYCLES(32'hA)
  ) u_trim_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .start_pin(start_pin),
    .poweron_trim_delay_select(dly_sel), .serial_control_mode(ser_mode),
    .output_clock_reset_input(trig), .sample_in(sample_in),
    .sample_out(sample_out), .output_clock(output_clock),
    .trim_in_progress(trim_in_progress)
  );

  host_model u_host_model (
    .hclk(hclk), .start_pin(start_pin), .poweron_trim_delay_select(dly_sel),
    .serial_control_mode(ser_mode), .output_clock_reset_input(trig)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // ----------------------------------------------------------------
  // Read result monitor
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_pend && hreadyout) begin
      exp_v = exp_q.pop_front();
      `CHK(hrdata, exp_v)
      `CHK(hresp, 1'b0)
    end
  end

  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task tmo();
    n_fail++;
    conclude();
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel    <= 1'b0;
    htrans  <= 2'b00;
    hwdata  <= d;
    rd_pend <= !w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    rd_pend <= 1'b0;
    if (k >= 50) tmo();
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  task quiet(input int n);
    repeat (n) begin
      @(negedge hclk);
      `CHK(trim_in_progress, 1'b0)
    end
  endtask

  task trim_chk(input int exp_len);
    int k;
    logic oc;
    k = 0;
    while (trim_in_progress !== 1'b1 && k < 2000) begin
      @(negedge hclk);
      k++;
    end
    if (k >= 2000) tmo();
    k = 0;
    oc = ~output_clock;
    while (trim_in_progress === 1'b1 && k < 2000) begin
      `CHK(sample_out, 50'h0)
      `CHK(output_clock, ~oc)
      oc = output_clock;
      @(negedge hclk);
      k++;
    end
    `CHK(k, exp_len)
    repeat (60) begin
      `CHK(sample_out, 50'h0)
      @(negedge hclk);
    end
  endtask

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hwdata = '0; rd_pend = 1'b0;
    n_fail = 0; samples_checked = 0; rng = 32'h96E4;
    r = {xs(), xs()};
    sample_in = r[49:0];
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h4000);
    rd(8'h0C, 32'h0);
    trim_chk(RES + LIN);
    $display("test power-on trim done");
    u_host_model.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    trim_chk(RES + LIN);
    $display("test delay toggle done");
    u_host_model.req(100, 40);
    quiet(150);
    ahb(1'b1, 8'h04, 32'h0);
    fork
      u_host_model.req(100, 100);
      trim_chk(LIN);
    join
    $display("test pin request done");
    u_host_model.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (100) @(posedge hclk);
    ahb(1'b1, 8'h00, 32'h8000);
    trim_chk(LIN);
    fork
      u_host_model.req(100, 100);
      quiet(250);
    join
    $display("test start bit done");
    ahb(1'b1, 8'h00, 32'h0008);
    for (int t = 0; t < 2; t++) begin
      r = {xs(), xs()};
      fork
        u_host_model.set_pins(1'b0, 1'b1, 1'b1, t[0]);
        begin @(posedge hclk); sample_in <= r[49:0]; end
      join
      repeat (8) begin
        @(negedge hclk);
        if (sample_out.word[0][11:1] === r[13:3]) begin
          `CHK(sample_out.word[0][0], t[0])
        end
      end
      for (int i = 0; i < 4; i++) begin
        `CHK(sample_out.word[i], {r[i*12+3 +: 11], t[0]})
      end
      `CHK(sample_out.over_range, r[1:0])
    end
    $display("test capture done");
    ahb(1'b1, 8'h00, 32'h0);
    u_host_model.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    quiet(200);
    rd(8'h08, 32'h4);
    fork
      u_host_model.req(100, 100);
      trim_chk(RES + LIN);
    join
    $display("test skip done");
    conclude();
  end
endmodule
